// >>> eps_core_mdl.sv
// Core-side model: bus master and exception state source.
`timescale 1ns/1ns
`default_nettype none

module eps_core_mdl
  import eps_pkg::*;
(
  // Clock.
  input  wire logic        clock,
  // Avalon-MM master.
  output logic [11:0]      address,
  output logic             read,
  output logic             write,
  output logic [3:0]       byteenable,
  output logic [31:0]      writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  // Prioritisation logic, core and tick timer.
  output eps_exc_state_t   exc_state,
  output eps_taken_t       taken,
  output logic             tick_event
);
  initial begin
    {read, write, tick_event} = 3'h0;
    {address, byteenable, writedata} = 48'h0;
    exc_state = '0;
    taken = '0;
  end

  // The request stands until waitrequest is sampled low.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clock);
    address <= a;
    byteenable <= be;
    writedata <= d;
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // A released bus must not keep showing the last value.
    address <= ~a;
    writedata <= ~d;
  endtask

  task automatic set_es(input eps_exc_state_t v);
    @(posedge clock);
    exc_state <= v;
  endtask

  // One-cycle pulse: 0 tick timer, 1 tick taken, 2 deferred taken.
  task automatic pulse(input int k);
    @(posedge clock);
    tick_event <= (k == 0);
    taken <= {k == 2, k == 1};
    @(posedge clock);
    tick_event <= 1'b0;
    taken <= '0;
  endtask
endmodule

`default_nettype wire

// >>> eps_evt_irq.sv
// Sticky event status, mask and level interrupt output.
`timescale 1ns/1ns
`default_nettype none

module eps_evt_irq
  import eps_pkg::*;
#(
  parameter int N = EVT_NUM
)
(
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst,
  // Event pulses.
  input  wire logic [N-1:0] evt,
  // Software side.
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] mask_wdata,
  input  wire logic         stat_clr,
  input  wire logic [N-1:0] clr_bits,
  // State and interrupt.
  output logic [N-1:0]      status,
  output logic [N-1:0]      mask,
  output logic              irq
);

  logic [N-1:0] status_r;
  logic [N-1:0] mask_r;
  logic         irq_r;
  wire  [N-1:0] clr_mask;
  wire  [N-1:0] status_nxt;
  wire  [N-1:0] mask_nxt;
  wire          irq_nxt;

  if (N < 1 || N > 32) begin : g_chk
    $error("eps_evt_irq: N must be 1 to 32");
  end

  // A new event wins over a read clear in the same cycle.
  assign clr_mask   = stat_clr ? clr_bits : '0;
  assign status_nxt = evt | (status_r & ~clr_mask);
  assign mask_nxt   = mask_wr ? mask_wdata : mask_r;
  assign irq_nxt    = |(status_nxt & mask_nxt);

  always_ff @(posedge clock) begin
    if (rst) begin
      status_r <= N'(EVT_RST);
      mask_r   <= N'(EVT_RST);
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      mask_r   <= mask_nxt;
      irq_r    <= irq_nxt;
    end
  end

  assign status = status_r;
  assign mask   = mask_r;
  assign irq    = irq_r;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  evt_sticky_a : assert property (|evt |-> ##1 (status_r & $past(evt)) == $past(evt))
    else $error("event did not set its status bit");
  irq_level_a : assert property (##1 irq_r == |(status_r & mask_r))
    else $error("interrupt level does not follow status and mask");

endmodule

`default_nettype wire

// >>> eps_interrupt_control_state.sv
// Interrupt control and state register with its Avalon-MM slave.
`timescale 1ns/1ns
`default_nettype none

module eps_interrupt_control_state
  import eps_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst,
  // Avalon-MM slave.
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [3:0]        avs_byteenable,
  input  wire logic [31:0]       avs_writedata,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Prioritisation logic, core and tick timer.
  input  wire eps_exc_state_t    exc_state,
  input  wire eps_taken_t        taken,
  input  wire logic              tick_event,
  // Pending state towards the prioritisation logic.
  output logic                   deferred_service_pending,
  output logic                   tick_pending,
  // Interrupt.
  output logic                   irq
);

  if (ADDR_W < 12 || ADDR_W > 32) begin : g_chk
    $error("eps_interrupt_control_state: ADDR_W must be 12 to 32");
  end

  // Builds the read view of interrupt_control_state.
  function automatic logic [31:0] ics_view(
    input logic           sv,
    input logic           st,
    input eps_exc_state_t es
  );
    logic [31:0] v;
    v = ICS_RST;
    v[SV_SET_BIT]  = sv;
    v[ST_SET_BIT]  = st;
    v[PREEMPT_BIT] = es.debug_exit_preempt;
    v[IRQP_BIT]    = es.irq_pending_flag;
    v[HIGH_LSB +: EXC_W] = es.highest_pending_number;
    v[ACT_LSB +: EXC_W]  = es.active_exception_number;
    return v;
  endfunction

  // Full address compare, so aliases and misaligned addresses miss.
  function automatic logic addr_is(
    input logic [ADDR_W-1:0] a,
    input logic [11:0]       ofs
  );
    return a == ADDR_W'(ofs);
  endfunction

  // Registers.
  logic                wait_r;
  logic [31:0]         rdata_r;
  logic                sv_pend_r;
  logic                st_pend_r;
  logic                irqp_r;

  // Next values.
  logic                wait_nxt;
  logic [31:0]         rdata_nxt;
  logic                sv_pend_nxt;
  logic                st_pend_nxt;

  // Event block signals.
  wire  [EVT_NUM-1:0]  evt;
  logic [EVT_NUM-1:0]  evt_status;
  logic [EVT_NUM-1:0]  evt_mask;

  // Bus phase decode.
  wire req    = avs_read | avs_write;
  wire wr_acc = avs_write & ~wait_r;
  wire rd_acc = avs_read & ~wait_r;
  wire rd_cap = avs_read & wait_r;

  // Address decode.
  wire hit_ics  = addr_is(avs_address, ICS_OFS);
  wire hit_stat = addr_is(avs_address, EVT_STAT_OFS);
  wire hit_mask = addr_is(avs_address, EVT_MASK_OFS);

  // Only byte lane 3 carries the set and clear bits.
  wire ics_wr  = wr_acc & hit_ics & avs_byteenable[3];
  wire mask_wr = wr_acc & hit_mask & avs_byteenable[0];

  wire sv_set_wr = ics_wr & avs_writedata[SV_SET_BIT];
  wire sv_clr_wr = ics_wr & avs_writedata[SV_CLR_BIT];
  wire st_set_wr = ics_wr & avs_writedata[ST_SET_BIT];
  wire st_clr_wr = ics_wr & avs_writedata[ST_CLR_BIT];

  // deferred service has no hardware set source.
  // a set in the same write overrides the clear.
  assign sv_pend_nxt = sv_set_wr |
                       (sv_pend_r & ~sv_clr_wr & ~taken.deferred_taken);

  // set wins over clear, also for the timer event.
  assign st_pend_nxt = st_set_wr | tick_event |
                       (st_pend_r & ~st_clr_wr & ~taken.tick_taken);

  // reserved and unmapped bits read as zero.
  wire [31:0] stat_view = 32'(evt_status);
  wire [31:0] mask_view = 32'(evt_mask);
  // the read view carries the pending state.
  // the tick set bit reads the tick pending state.
  wire [31:0] ics_rd = ics_view(sv_pend_r, st_pend_r, exc_state);
  wire [31:0] rd_mux = hit_ics  ? ics_rd    :
                       hit_stat ? stat_view :
                       hit_mask ? mask_view : 32'h0000_0000;

  // One wait cycle: request seen, then accepted with data ready.
  assign wait_nxt  = ~(req & wait_r);
  assign rdata_nxt = rd_cap ? rd_mux : rdata_r;

  // Events: deferred or tick newly pending, interrupt flag rising.
  assign evt[EVT_SV]   = sv_pend_nxt & ~sv_pend_r;
  assign evt[EVT_TICK] = st_pend_nxt & ~st_pend_r;
  assign evt[EVT_IRQP] = exc_state.irq_pending_flag & ~irqp_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      wait_r <= 1'b1;
      rdata_r <= RDATA_RST;
      irqp_r <= 1'b0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      irqp_r <= exc_state.irq_pending_flag;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sv_pend_r <= ICS_RST[SV_SET_BIT];
      st_pend_r <= ICS_RST[ST_SET_BIT];
    end else begin
      sv_pend_r <= sv_pend_nxt;
      st_pend_r <= st_pend_nxt;
    end
  end

  // A status read clears only the bits that the read returned, so an
  // event that lands during the wait cycle is kept.
  eps_evt_irq #(
    .N (EVT_NUM)
  ) u_evt (
    .clock      (clock),
    .rst        (rst),
    .evt        (evt),
    .mask_wr    (mask_wr),
    .mask_wdata (avs_writedata[EVT_NUM-1:0]),
    .stat_clr   (rd_acc & hit_stat),
    .clr_bits   (rdata_r[EVT_NUM-1:0]),
    .status     (evt_status),
    .mask       (evt_mask),
    .irq        (irq)
  );

  assign avs_readdata             = rdata_r;
  assign avs_waitrequest          = wait_r;
  assign deferred_service_pending = sv_pend_r;
  assign tick_pending             = st_pend_r;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  wire ics_wacc = avs_write & ~wait_r & hit_ics & avs_byteenable[3];
  wire ics_racc = avs_read & ~wait_r & hit_ics;

  sv_set_a : assert property (
    ics_wacc && avs_writedata[SV_SET_BIT] |=> sv_pend_r)
    else $error("deferred set write did not pend");

  sv_hold_a : assert property (
    ics_wacc && !avs_writedata[SV_SET_BIT] &&
    !avs_writedata[SV_CLR_BIT] && !taken.deferred_taken
    |=> $stable(sv_pend_r))
    else $error("deferred write of zero changed state");

  sv_only_sw_a : assert property (
    $rose(sv_pend_r) |-> $past(ics_wacc) &&
    $past(avs_writedata[SV_SET_BIT]))
    else $error("deferred pending set without software write");

  sv_clr_a : assert property (
    ics_wacc && avs_writedata[SV_CLR_BIT] &&
    !avs_writedata[SV_SET_BIT] |=> !sv_pend_r)
    else $error("deferred clear write did not clear");

  st_set_a : assert property (
    ics_wacc && avs_writedata[ST_SET_BIT] |=> st_pend_r)
    else $error("tick set write did not pend");

  st_clr_a : assert property (
    ics_wacc && avs_writedata[ST_CLR_BIT] &&
    !avs_writedata[ST_SET_BIT] && !tick_event |=> !st_pend_r)
    else $error("tick clear write did not clear");

  rd_pend_a : assert property (
    ics_racc |-> avs_readdata[SV_SET_BIT] == $past(sv_pend_r))
    else $error("deferred set bit read wrong state");

  rd_tick_a : assert property (
    ics_racc |-> avs_readdata[ST_SET_BIT] == $past(st_pend_r))
    else $error("tick set bit read wrong state");

  rd_flags_a : assert property (
    ics_racc |-> avs_readdata[PREEMPT_BIT] ==
    $past(exc_state.debug_exit_preempt))
    else $error("preempt flag read wrong");

  rd_irqp_a : assert property (
    ics_racc |-> avs_readdata[IRQP_BIT] ==
    $past(exc_state.irq_pending_flag))
    else $error("interrupt pending flag read wrong");

  rd_high_a : assert property (
    ics_racc |-> avs_readdata[HIGH_LSB +: EXC_W] ==
    $past(exc_state.highest_pending_number))
    else $error("highest pending number read wrong");

  rd_active_a : assert property (
    ics_racc |-> avs_readdata[ACT_LSB +: EXC_W] ==
    $past(exc_state.active_exception_number))
    else $error("active exception number read wrong");

  rsvd_zero_a : assert property (
    ics_racc |-> avs_readdata[31:29] == 3'h0 &&
    avs_readdata[SV_CLR_BIT] == 1'b0 &&
    avs_readdata[ST_CLR_BIT] == 1'b0 &&
    avs_readdata[24] == 1'b0 &&
    avs_readdata[21:18] == 4'h0 &&
    avs_readdata[11:6] == 6'h00)
    else $error("reserved or write-only bits read nonzero");

  // Write masks, read side effects and event sources.
  st_hold_a : assert property (
    ics_wacc && !avs_writedata[ST_SET_BIT] &&
    !avs_writedata[ST_CLR_BIT] && !tick_event && !taken.tick_taken
    |=> $stable(st_pend_r))
    else $error("tick write of zero changed state");

  sv_clr_zero_a : assert property (
    ics_wacc && !avs_writedata[SV_CLR_BIT] && !taken.deferred_taken
    && sv_pend_r |=> sv_pend_r)
    else $error("deferred pending lost without clear");

  st_clr_zero_a : assert property (
    ics_wacc && !avs_writedata[ST_CLR_BIT] && !taken.tick_taken
    && st_pend_r |=> st_pend_r)
    else $error("tick pending lost without clear");

  // Lane three carries every set and clear bit.
  lane_off_a : assert property (
    avs_write && !wait_r && hit_ics && !avs_byteenable[3] &&
    taken == '0 && !tick_event
    |=> $stable(sv_pend_r) && $stable(st_pend_r))
    else $error("write with lane three off changed state");

  unmapped_wr_a : assert property (
    wr_acc && !hit_ics && !hit_mask && taken == '0 && !tick_event
    |=> $stable(sv_pend_r) && $stable(st_pend_r) &&
    $stable(evt_mask))
    else $error("write outside the map changed state");

  // Unmapped reads answer with zero at normal timing.
  unmapped_rd_a : assert property (
    rd_acc && !hit_ics && !hit_stat && !hit_mask
    |-> avs_readdata == 32'h0000_0000)
    else $error("read outside the map returned data");

  tick_evt_a : assert property (tick_event |=> st_pend_r)
    else $error("tick timer event did not pend");

  sv_evt_a : assert property (
    $rose(sv_pend_r) |-> evt_status[EVT_SV])
    else $error("deferred pending did not raise its event");

  st_evt_a : assert property (
    $rose(st_pend_r) |-> evt_status[EVT_TICK])
    else $error("tick pending did not raise its event");

  irqp_evt_a : assert property (
    $rose(exc_state.irq_pending_flag) |=> evt_status[EVT_IRQP])
    else $error("interrupt flag rise did not raise its event");

  // Returned bits clear unless a new event lands in the same cycle.
  stat_clear_a : assert property (
    rd_acc && hit_stat |=> (evt_status &
    $past(avs_readdata[EVT_NUM-1:0]) & ~$past(evt)) == '0)
    else $error("status read did not clear returned bits");

  mask_write_a : assert property (
    mask_wr |=> evt_mask == $past(avs_writedata[EVT_NUM-1:0]))
    else $error("mask write did not land");

  // Read data stand until the next read is captured.
  rdata_hold_a : assert property (!rd_cap |=> $stable(avs_readdata))
    else $error("read data changed outside a read");

  bus_wait_a : assert property (
    req && wait_r |=> !wait_r ##1 wait_r)
    else $error("waitrequest did not answer in one cycle");

  sv_set_c : cover property (ics_wacc && avs_writedata[SV_SET_BIT]);
  st_clr_c : cover property (st_pend_r ##1 !st_pend_r);
  stat_rd_c : cover property (rd_acc && hit_stat && |avs_readdata);
  irq_c : cover property ($rose(irq));
  tick_c : cover property (tick_event ##1 st_pend_r);

endmodule

`default_nettype wire

// >>> eps_pkg.sv
// Constants and carrier types of the exception pending state register.
`default_nettype none

package eps_pkg;

  // Register offsets on the Avalon-MM slave, byte addresses.
  localparam logic [11:0] ICS_OFS      = 12'hd04;
  localparam logic [11:0] EVT_STAT_OFS = 12'hd40;
  localparam logic [11:0] EVT_MASK_OFS = 12'hd44;

  // Field positions of interrupt_control_state.
  localparam int SV_SET_BIT  = 28;
  localparam int SV_CLR_BIT  = 27;
  localparam int ST_SET_BIT  = 26;
  localparam int ST_CLR_BIT  = 25;
  localparam int PREEMPT_BIT = 23;
  localparam int IRQP_BIT    = 22;
  localparam int HIGH_LSB    = 12;
  localparam int ACT_LSB     = 0;
  localparam int EXC_W       = 6;

  // Reset values.
  localparam logic [31:0] ICS_RST   = 32'h0000_0000;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Event status and mask layout.
  localparam int EVT_NUM    = 3;
  localparam int EVT_SV     = 0;
  localparam int EVT_TICK   = 1;
  localparam int EVT_IRQP   = 2;
  localparam logic [EVT_NUM-1:0] EVT_RST = 3'h0;

  // Cycles from a request to the cycle in which waitrequest is low.
  localparam int WAIT_CYCLES = 1;

  // State reported by the exception prioritisation logic.
  typedef struct packed {
    logic             debug_exit_preempt;
    logic             irq_pending_flag;
    logic [EXC_W-1:0] highest_pending_number;
    logic [EXC_W-1:0] active_exception_number;
  } eps_exc_state_t;

  // Pulses from the core when it enters a handler.
  typedef struct packed {
    logic deferred_taken;
    logic tick_taken;
  } eps_taken_t;

endpackage

`default_nettype wire

// >>> testbench.sv
// Self-checking bench of the exception pending state register.
`timescale 1ns/1ns
`default_nettype none

module testbench
  import eps_pkg::*;
;
  logic           clock = 1'b0;
  logic           rst = 1'b1;
  logic [11:0]    address;
  logic           read;
  logic           write;
  logic [3:0]     byteenable;
  logic [31:0]    writedata;
  logic [31:0]    readdata;
  logic           waitrequest;
  eps_exc_state_t exc_state;
  eps_taken_t     taken;
  logic           tick_event;
  logic           sv_pend;
  logic           st_pend;
  logic           irq;
  logic [31:0]    q;
  logic [31:0]    r;
  int             n_fail = 0;
  int             total_checks = 0;
  int             seed = 32'hf0c2;
  int             pm [2];
  int             setb [2] = '{SV_SET_BIT, ST_SET_BIT};
  int             clrb [2] = '{SV_CLR_BIT, ST_CLR_BIT};

  always #20 clock = ~clock;

  eps_interrupt_control_state #(.ADDR_W(12)) i_eps_interrupt_control_state (
    .clock(clock), .rst(rst), .avs_address(address), .avs_read(read),
    .avs_write(write), .avs_byteenable(byteenable),
    .avs_writedata(writedata), .avs_readdata(readdata),
    .avs_waitrequest(waitrequest), .exc_state(exc_state), .taken(taken),
    .tick_event(tick_event), .deferred_service_pending(sv_pend),
    .tick_pending(st_pend), .irq(irq));

  eps_core_mdl i_eps_core_mdl (
    .clock(clock), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .exc_state(exc_state), .taken(taken),
    .tick_event(tick_event));

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    i_eps_core_mdl.xfer(1'b1, a, 4'hf, d, q);
  endtask

  task automatic rd(input logic [11:0] a);
    i_eps_core_mdl.xfer(1'b0, a, 4'($random(seed)), $random(seed), q);
  endtask

  // Whole register and both pending outputs against the model.
  task automatic chk_ics();
    logic [31:0] e;
    rd(ICS_OFS);
    e = (32'(pm[0]) << SV_SET_BIT) | (32'(pm[1]) << ST_SET_BIT)
      | (32'(exc_state.debug_exit_preempt) << PREEMPT_BIT)
      | (32'(exc_state.irq_pending_flag) << IRQP_BIT)
      | (32'(exc_state.highest_pending_number) << HIGH_LSB)
      | (32'(exc_state.active_exception_number) << ACT_LSB);
    chk("ics", q, e);
    chk("sv_pend", {31'h0, sv_pend}, 32'(pm[0]));
    chk("st_pend", {31'h0, st_pend}, 32'(pm[1]));
  endtask

  initial begin
    pm = '{0, 0};
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    chk_ics();
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      // Lane 3 off: set bit must be ignored.
      i_eps_core_mdl.xfer(1'b1, ICS_OFS, {1'b0, 3'($random(seed))},
                          32'h1 << setb[k], q);
      chk_ics();
      wr(ICS_OFS, 32'h1 << setb[k]);
      pm[k] = 1;
      chk_ics();
      wr(ICS_OFS, 32'h0);
      chk_ics();
      wr(ICS_OFS, 32'h613c_0fc0);
      chk_ics();
      // Clear with the set bit written as zero.
      wr(ICS_OFS, 32'h1 << clrb[k]);
      pm[k] = 0;
      chk_ics();
    end
    $display("test set clear done");
    i_eps_core_mdl.pulse(0);
    pm[1] = 1;
    chk_ics();
    i_eps_core_mdl.pulse(1);
    pm[1] = 0;
    wr(ICS_OFS, 32'h1 << SV_SET_BIT);
    i_eps_core_mdl.pulse(2);
    chk_ics();
    rd(12'hd08);
    chk("unmapped", q, 32'h0);
    wr(12'hd08, 32'hffff_ffff);
    chk_ics();
    $display("test sources done");
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      i_eps_core_mdl.set_es(r[13:0]);
      chk_ics();
    end
    i_eps_core_mdl.set_es('0);
    chk_ics();
    $display("test fields done");
    rd(EVT_STAT_OFS);
    wr(EVT_MASK_OFS, 32'h1);
    wr(ICS_OFS, 32'h1 << SV_SET_BIT);
    pm[0] = 1;
    repeat (3) @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(EVT_STAT_OFS);
    chk("status", q, 32'h1);
    repeat (3) @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h0);
    // Masked tick event: status only, no interrupt.
    i_eps_core_mdl.pulse(0);
    pm[1] = 1;
    repeat (3) @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h0);
    rd(EVT_STAT_OFS);
    chk("status", q, 32'h2);
    wr(EVT_MASK_OFS, 32'h4);
    rd(EVT_MASK_OFS);
    chk("mask", q, 32'h4);
    i_eps_core_mdl.set_es(14'h1000);
    repeat (3) @(posedge clock);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(EVT_STAT_OFS);
    chk("status", q, 32'h4);
    chk_ics();
    $display("test interrupt done");
    summarize();
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule

`default_nettype wire
